// *** bsc_backplane.v ***
// backplane status and control signal generation for a cpu board
// assumes processor-side signals are on sys_clk_i; bus card pins and
// the phase-2 clock arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`include "bsc_consts.vh"

module bsc_backplane #(
  parameter POWER_ON_MEMORY_DISABLE_CYC = `BSC_POWER_ON_MEMORY_DISABLE_CYC
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire cpu_sync_i,
  input wire [`BSC_ST_WIDTH-1:0] cpu_status_i,
  input wire cpu_dbin_i,
  input wire cpu_wr_n_i,
  input wire [7:0] cpu_dout_i,
  input wire phase2_clk_i,
  input wire data_input_gate_i,
  input wire front_panel_ready_i,
  input wire startup_done_i,
  output reg fetch_cycle_status_o,
  output reg output_cycle_status_o,
  output reg input_cycle_status_o,
  output reg memory_read_status_o,
  output reg halt_ack_status_o,
  output reg bus_clock_o,
  output reg cycle_start_sync_o,
  output reg data_in_strobe_o,
  output reg buffered_data_in_strobe_o,
  output reg input_mux_sel_bus_o,
  output reg processor_write_strobe_n_o,
  output reg memory_write_strobe_o,
  output reg memory_write_strobe_oe_o,
  output reg [7:0] bidirectional_data_bus_o,
  output reg bidirectional_data_bus_oe_o,
  output reg power_on_memory_disable_n_o
);
  localparam CW = 32;
  localparam [CW-1:0] PH_LAST = POWER_ON_MEMORY_DISABLE_CYC - 1;
  // bit positions in the qualifier word
  localparam QW = 5;
  localparam Q_M1 = 4;
  localparam Q_OUT = 3;
  localparam Q_INP = 2;
  localparam Q_MEMR = 1;
  localparam Q_HLTA = 0;

  // external pins: phase-2, data input gate, front panel ready
  // reset to the idle levels so no false override follows reset
  wire [2:0] pin_sync;
  bsc_sync2 #(
    .WIDTH(3),
    .RST_VAL(`BSC_PIN_RST)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({data_input_gate_i, front_panel_ready_i, phase2_clk_i}),
    .q_o(pin_sync)
  );
  wire dig_s = pin_sync[2];
  wire front_panel_ready_s = pin_sync[1];
  wire ph2_s = pin_sync[0];

  // qualifier cleanup: fetch implies memory read, one transfer kind only
  function [4:0] bsc_qual;
    input [`BSC_ST_WIDTH-1:0] st;
    reg m1;
    reg inp;
    reg outp;
    begin
      m1 = st[`BSC_ST_M1];
      inp = st[`BSC_ST_INP] & ~m1;
      outp = st[`BSC_ST_OUT] & ~m1 & ~inp;
      // {m1, out, inp, memr, hlta}
      bsc_qual = {m1, outp, inp,
                  m1 | (st[`BSC_ST_MEMR] & ~inp & ~outp),
                  st[`BSC_ST_HLTA]};
    end
  endfunction

  wire [QW-1:0] qual = bsc_qual(cpu_status_i);
  wire wr_act = ~cpu_wr_n_i;
  wire dbin_gated = cpu_dbin_i & dig_s;
  // latched status word, same bit order as the qualifier word
  wire [QW-1:0] status_q = {fetch_cycle_status_o,
                            output_cycle_status_o,
                            input_cycle_status_o,
                            memory_read_status_o,
                            halt_ack_status_o};
  wire [QW-1:0] status_nxt;

  // each status bit reloads on sync and otherwise holds for the cycle
  genvar gi;
  generate
    for (gi = 0; gi < QW; gi = gi + 1) begin : g_status
      assign status_nxt[gi] = cpu_sync_i ? qual[gi] : status_q[gi];
    end
  endgenerate

  // next values, one for each output flop
  reg sync_nxt;
  reg clock_nxt;
  reg dbin_nxt;
  reg dbin_buf_nxt;
  reg mux_sel_nxt;
  reg wr_n_nxt;
  reg mw_strobe_nxt;
  reg mw_oe_nxt;
  reg [7:0] dout_hold_r;
  reg [7:0] dout_hold_nxt;
  reg [7:0] dbus_nxt;
  reg dbus_oe_nxt;
  reg [CW-1:0] ph_cnt_r;
  reg [CW-1:0] ph_cnt_nxt;
  reg ph_done;
  reg disable_n_nxt;

  // strobes and pin overrides
  always @* begin
    sync_nxt = cpu_sync_i;
    // pins pass the synchroniser, so this lags the pin by three clocks
    clock_nxt = ~ph2_s;
    dbin_nxt = cpu_dbin_i;
    // a low gate holds the buffered strobe off
    dbin_buf_nxt = dbin_gated;
    // low gate or input cycle: the processor takes data from the bus
    mux_sel_nxt = ~dig_s | input_cycle_status_o;
    wr_n_nxt = cpu_wr_n_i;
    // output cycles use the write strobe but never the memory write
    mw_strobe_nxt = wr_act & ~output_cycle_status_o;
    mw_oe_nxt = front_panel_ready_s;
  end

  // outgoing data and its driver enable
  always @* begin
    // capture data before the strobe, freeze it while the strobe is on
    dout_hold_nxt = wr_act ? dout_hold_r : cpu_dout_i;
    dbus_nxt = wr_act ? dout_hold_r : cpu_dout_i;
    // drive while not reading or while writing, but never during a
    // read that a card has gated off
    dbus_oe_nxt = (~cpu_dbin_i | wr_act) & ~(cpu_dbin_i & ~dig_s);
  end

  // power-on timer: stops at its last count instead of wrapping
  always @* begin
    ph_done = (ph_cnt_r == PH_LAST);
    ph_cnt_nxt = ph_done ? ph_cnt_r : ph_cnt_r + 32'h1;
    // memories stay off until the timer ran out and startup is done
    disable_n_nxt = ph_done & startup_done_i;
  end

  // status word and cycle marker
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_cycle_status_o <= `BSC_STATUS_RST;
      output_cycle_status_o <= `BSC_STATUS_RST;
      input_cycle_status_o <= `BSC_STATUS_RST;
      memory_read_status_o <= `BSC_STATUS_RST;
      halt_ack_status_o <= `BSC_STATUS_RST;
      cycle_start_sync_o <= `BSC_STROBE_RST;
    end else begin
      fetch_cycle_status_o <= status_nxt[Q_M1];
      output_cycle_status_o <= status_nxt[Q_OUT];
      input_cycle_status_o <= status_nxt[Q_INP];
      memory_read_status_o <= status_nxt[Q_MEMR];
      halt_ack_status_o <= status_nxt[Q_HLTA];
      cycle_start_sync_o <= sync_nxt;
    end
  end

  // strobes, data and driver enables
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_clock_o <= `BSC_CLOCK_RST;
      data_in_strobe_o <= `BSC_STROBE_RST;
      buffered_data_in_strobe_o <= `BSC_STROBE_RST;
      input_mux_sel_bus_o <= `BSC_STROBE_RST;
      processor_write_strobe_n_o <= `BSC_WR_N_RST;
      memory_write_strobe_o <= `BSC_STROBE_RST;
      memory_write_strobe_oe_o <= `BSC_STROBE_RST;
      dout_hold_r <= `BSC_DATA_RST;
      bidirectional_data_bus_o <= `BSC_DATA_RST;
      bidirectional_data_bus_oe_o <= `BSC_STROBE_RST;
    end else begin
      bus_clock_o <= clock_nxt;
      data_in_strobe_o <= dbin_nxt;
      buffered_data_in_strobe_o <= dbin_buf_nxt;
      input_mux_sel_bus_o <= mux_sel_nxt;
      processor_write_strobe_n_o <= wr_n_nxt;
      memory_write_strobe_o <= mw_strobe_nxt;
      memory_write_strobe_oe_o <= mw_oe_nxt;
      dout_hold_r <= dout_hold_nxt;
      bidirectional_data_bus_o <= dbus_nxt;
      bidirectional_data_bus_oe_o <= dbus_oe_nxt;
    end
  end

  // power-on memory disable
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_cnt_r <= {CW{1'b0}};
      power_on_memory_disable_n_o <= `BSC_DISABLE_N_RST;
    end else begin
      ph_cnt_r <= ph_cnt_nxt;
      power_on_memory_disable_n_o <= disable_n_nxt;
    end
  end
endmodule

// *** bsc_backplane_asserts.sv ***
// checker for the backplane status and control outputs
// assumes it is bound onto bsc_backplane, one clock domain
`timescale 1ns/1ps
module bsc_chk (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire cpu_sync_i,
  input wire [5:0] cpu_status_i,
  input wire phase2_clk_i,
  input wire data_input_gate_i,
  input wire front_panel_ready_i,
  input wire startup_done_i,
  input wire fetch_cycle_status_o,
  input wire memory_read_status_o,
  input wire halt_ack_status_o,
  input wire bus_clock_o,
  input wire cycle_start_sync_o,
  input wire buffered_data_in_strobe_o,
  input wire input_mux_sel_bus_o,
  input wire memory_write_strobe_oe_o,
  input wire power_on_memory_disable_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_sync_pulse: assert property (cpu_sync_i |=> cycle_start_sync_o)
    else $error("sync pulse missing");
  chk_fetch_memr: assert property (cpu_sync_i && cpu_status_i[2] |=>
    fetch_cycle_status_o && memory_read_status_o) else $error("fetch bad");
  chk_halt_ack: assert property (cpu_sync_i |=>
    halt_ack_status_o == $past(cpu_status_i[4])) else $error("halt bad");
  chk_status_held: assert property (!cpu_sync_i |=>
    $stable(fetch_cycle_status_o) && $stable(memory_read_status_o))
    else $error("status moved");
  chk_clock_inv: assert property (bus_clock_o == !$past(phase2_clk_i, 3))
    else $error("bus clock bad");
  chk_gate_force: assert property (!data_input_gate_i [*4] |->
    !buffered_data_in_strobe_o && input_mux_sel_bus_o) else $error("gate");
  chk_ready_oe: assert property (!front_panel_ready_i [*4] |->
    !memory_write_strobe_oe_o) else $error("write driver on");
  chk_power_on_memory_disable_hold: assert property (!startup_done_i |=>
    !power_on_memory_disable_n_o) else $error("power_on_memory_disable released");
endmodule
bind bsc_backplane bsc_chk u_chk (.*);

// *** bsc_card.sv ***
// bus card model: drives the gate and ready pins of the backplane
// assumes the bench commands when the card steals or blocks
`timescale 1ns/1ps
module bsc_card (
  input wire steal_i,
  input wire block_i,
  output wire gate_n_o,
  output wire ready_o
);
  assign gate_n_o = !steal_i;
  assign ready_o = !block_i;
endmodule

// *** bsc_consts.vh ***
// constants for the backplane status/control block
// assumes inclusion by bare name from the design files
`ifndef BSC_CONSTS_VH
`define BSC_CONSTS_VH
// processor status word bit positions, sampled at cycle start
`define BSC_ST_MEMR 0
`define BSC_ST_INP 1
`define BSC_ST_M1 2
`define BSC_ST_OUT 3
`define BSC_ST_HLTA 4
`define BSC_ST_W 5
`define BSC_ST_WIDTH 6
// reset values of the status outputs
`define BSC_STATUS_RST 1'b0
// reset values of the strobes, drivers and pin synchronisers
`define BSC_STROBE_RST 1'h0
`define BSC_CLOCK_RST 1'h1
`define BSC_WR_N_RST 1'h1
`define BSC_DATA_RST 8'h00
`define BSC_DISABLE_N_RST 1'h0
// gate and ready idle high, phase-2 low
`define BSC_PIN_RST 3'h6
// power-on memory disable time in ns and derived cycles at 250 MHz
`define BSC_CLK_MHZ 250
`define BSC_POWER_ON_MEMORY_DISABLE_NS 4000
`define BSC_POWER_ON_MEMORY_DISABLE_CYC ((`BSC_POWER_ON_MEMORY_DISABLE_NS * `BSC_CLK_MHZ) / 1000)
`endif

// *** bsc_sync2.v ***
// two-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to sys_clk_i
`timescale 1ns/1ps
module bsc_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule

// *** test_backplane_status_control_signals.sv ***
// random and corner status cycles, card pin overrides, power-on disable
// assumes bsc_card on the gate and ready pins
`timescale 1ns/1ps
module test_backplane_status_control_signals;
  reg sys_clk_i = 0, rst_n_i = 0, sync = 0, dbin = 0, wr_n = 1, p2 = 0;
  reg done = 0, steal = 0, block = 0;
  reg [5:0] st = 6'h00;
  reg [7:0] dout = 8'h00;
  wire gate_n, rdy, sy, bds, mux, oe, boe, pd;
  wire bclk, dis, pws_n, mws;
  wire [7:0] dbus;
  wire [4:0] q;
  reg [7:0] d0;
  reg [4:0] e;
  integer n_fail = 0, samples_checked = 0, i, k;
  always #2 sys_clk_i = !sys_clk_i;
  bsc_card u_bsc_card (.steal_i(steal), .block_i(block),
    .gate_n_o(gate_n), .ready_o(rdy));
  bsc_backplane #(.POWER_ON_MEMORY_DISABLE_CYC(4)) u_bsc_backplane (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .cpu_sync_i(sync), .cpu_status_i(st),
    .cpu_dbin_i(dbin), .cpu_wr_n_i(wr_n), .cpu_dout_i(dout),
    .phase2_clk_i(p2), .data_input_gate_i(gate_n),
    .front_panel_ready_i(rdy), .startup_done_i(done),
    .fetch_cycle_status_o(q[4]), .input_cycle_status_o(q[3]),
    .output_cycle_status_o(q[2]), .memory_read_status_o(q[1]),
    .halt_ack_status_o(q[0]), .bus_clock_o(bclk), .cycle_start_sync_o(sy),
    .data_in_strobe_o(dis), .buffered_data_in_strobe_o(bds),
    .input_mux_sel_bus_o(mux), .processor_write_strobe_n_o(pws_n),
    .memory_write_strobe_o(mws), .memory_write_strobe_oe_o(oe),
    .bidirectional_data_bus_o(dbus), .bidirectional_data_bus_oe_o(boe),
    .power_on_memory_disable_n_o(pd));
  // {fetch, input, output, memory read, halt}: m1 wins, then inp, then out
  function [4:0] exp_st(input [5:0] s);
    exp_st = {s[2], s[1] & !s[2], s[3] & !s[2] & !s[1],
      s[2] | (s[0] & !s[1] & !s[3]), s[4]};
  endfunction
  task cmp(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    k = $urandom(42);
    repeat (8) @(negedge sys_clk_i);
    rst_n_i = 1;
    @(negedge sys_clk_i);
    cmp("power_on_memory_disable", 8'h00, pd);
    for (i = 0; i < 40; i = i + 1) begin
      // first five cycles walk each status code alone
      st = (i < 5) ? 6'h01 << i : $urandom;
      sync = 1;
      dbin = st[1];
      wr_n = !st[3];
      dout = $urandom;
      p2 = $urandom;
      @(negedge sys_clk_i);
      sync = 0;
      cmp("sync", 8'h01, sy);
      cmp("status", exp_st(st), q);
      @(negedge sys_clk_i);
      wr_n = 1;
      dbin = 0;
      cmp("held", exp_st(st), q);
      cmp("sync", 8'h00, sy);
    end
    $display("test status done");
    steal = 1;
    block = 1;
    dbin = 1;
    repeat (4) @(negedge sys_clk_i);
    cmp("gate", 8'h01, {bds, mux});
    cmp("drv", 8'h00, boe);
    cmp("mw_oe", 8'h00, oe);
    cmp("dbin", 8'h01, dis);
    cmp("clock", {7'h00, !p2}, bclk);
    steal = 0;
    block = 0;
    p2 = !p2;
    repeat (4) @(negedge sys_clk_i);
    e = exp_st(st);
    cmp("mw_oe", 8'h01, oe);
    cmp("bds", 8'h01, bds);
    cmp("mux", {7'h00, e[3]}, mux);
    cmp("clock", {7'h00, !p2}, bclk);
    dbin = 0;
    repeat (2) @(negedge sys_clk_i);
    cmp("drv", 8'h01, boe);
    cmp("dbin", 8'h00, dis);
    $display("test pins done");
    for (i = 0; i < 2; i = i + 1) begin
      // memory read cycle, then output cycle, each with one write
      st = i ? 6'h08 : 6'h01;
      sync = 1;
      dout = $urandom;
      d0 = dout;
      @(negedge sys_clk_i);
      sync = 0;
      wr_n = 0;
      dout = ~d0;
      repeat (2) @(negedge sys_clk_i);
      cmp("dbus", d0, dbus);
      cmp("wr_n", 8'h00, pws_n);
      cmp("memory_write_strobe", {7'h00, !i[0]}, mws);
      wr_n = 1;
      repeat (2) @(negedge sys_clk_i);
      cmp("dbus", ~d0, dbus);
    end
    $display("test write done");
    cmp("power_on_memory_disable", 8'h00, pd);
    done = 1;
    for (k = 0; k < 20 && pd !== 1'b1; k = k + 1) @(negedge sys_clk_i);
    cmp("power_on_memory_disable", 8'h01, pd);
    $display("test power_on_memory_disable done");
    wrap_up;
  end
endmodule
